// ==== hcs_regs.vh ====
// Register map, field positions and timing constants of the charge sequencer
`ifndef HCS_REGS_VH
`define HCS_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define HCS_ADDR_CTRL    8'h00
`define HCS_ADDR_STAT    8'h04
`define HCS_ADDR_IRQ     8'h08
`define HCS_ADDR_MASK    8'h0c
`define HCS_AW           8

// ****************************************************************
// Control fields
// ****************************************************************
`define HCS_CTRL_TRACK   0
`define HCS_CTRL_RESET   32'h0000_0001

// ****************************************************************
// Event bits (interrupt and mask registers share this layout; status has its own)
// ****************************************************************
`define HCS_EV_W         6
`define HCS_EV_HP_FAIL   0
`define HCS_EV_UV        1
`define HCS_EV_OV        2
`define HCS_EV_ABN       3
`define HCS_EV_SAMPLE    4
`define HCS_EV_BOOST     5

// ****************************************************************
// Timing (clk = 25 MHz)
// ****************************************************************
`define HCS_CLK_HZ       25000000
`define HCS_HOTPLUG_MS   45
`define HCS_HOLDOFF_MS   32
`define HCS_PERIOD_S     16
`define HCS_SAMPLE_MS    256
`define HCS_CNT_W        32

`endif

// ==== hcs_sequencer.v ====
// Harvester charge sequencer: comparator-driven switch, boost and sampling control
// Notes on behaviour
// [R1] Hot-plug closes the storage switch for about 45 ms to charge the rail capacitor.
// [R2] Rail above undervoltage within the window keeps switch closed; charge when input present.
// [R3] Window expiry without undervoltage level opens switch and enables cold start.
// [R4] Charged element with rail above ground keeps switch open until input source charges.
// [R5] Rail below undervoltage threshold opens the switch for rail recharge.
// [R6] Input above rail or storage is abnormal; boost and charger stay off. Only input above rail is detected here; storage is not compared.
// [R7] Cold start runs below main-boost level with input; main boost above it.
// [R8] After main boost starts, switch closes once rail reaches undervoltage release.
// [R9] Charging held off 32 ms after main converter turns on for first sample.
// [R10] Transfer pulses only while harvester input exceeds held reference.
// [R11] Boost disabled whenever rail reaches overvoltage.
// [R12] With tracking, every 16 s halt charger 256 ms and sample open-circuit input.
// [R13] Sample pin tied to rail suppresses sampling; outside may drive held reference.
// [R14] Tracking off: regulate to external reference; grounded reference removes regulation.
// [R15] Insufficient input: cold start may run forever, main boost stays off.
// [R16] Closed switch stays closed until rail falls below undervoltage threshold.
// [R17] After overvoltage, restart only below overvoltage release level.
// [R18] All intervals come from counters on one timebase, cleared at reset.
// [R19] Comparators synchronised before use; outputs come from registers.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "hcs_regs.vh"

module hcs_sequencer
#(
  parameter HOTPLUG_CYC = (`HCS_CLK_HZ / 1000) * `HCS_HOTPLUG_MS,
  parameter HOLDOFF_CYC = (`HCS_CLK_HZ / 1000) * `HCS_HOLDOFF_MS,
  parameter PERIOD_CYC  = `HCS_CLK_HZ * `HCS_PERIOD_S,
  parameter SAMPLE_CYC  = (`HCS_CLK_HZ / 1000) * `HCS_SAMPLE_MS
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Analog comparators
  input  wire        storage_attached,
  input  wire        rail_above_ground,
  input  wire        rail_above_boost_level,
  input  wire        rail_above_uv,
  input  wire        rail_above_uv_release,
  input  wire        rail_above_ov,
  input  wire        storage_above_ov_release,
  input  wire        input_present,
  input  wire        input_above_rail,
  input  wire        input_above_reference,
  input  wire        sample_pin_at_rail,
  input  wire        reference_grounded,
  // Power stage controls
  output reg         storage_switch_on,
  output reg         cold_start_en,
  output reg         main_boost_en,
  output reg         charger_en,
  output reg         transfer_pulse,
  output reg         sample_en,
  output reg         irq
);

// ****************************************************************
// Comparator synchronisers
// ****************************************************************
localparam NSYNC = 12;
wire [NSYNC-1:0] async_in = {reference_grounded, sample_pin_at_rail, input_above_reference,
                             input_above_rail, input_present, storage_above_ov_release,
                             rail_above_ov, rail_above_uv_release, rail_above_uv,
                             rail_above_boost_level, rail_above_ground, storage_attached};
reg  [NSYNC-1:0] sync1_r;
reg  [NSYNC-1:0] sync2_r;

// Comparators move freely against clk; two stages tame metastability
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    sync1_r <= {NSYNC{1'b0}};
    sync2_r <= {NSYNC{1'b0}};
  end
  else
  begin
    sync1_r <= async_in;  // [R19]
    sync2_r <= sync1_r;
  end
end

wire s_attach  = sync2_r[0];
wire s_gnd     = sync2_r[1];
wire s_boostlv = sync2_r[2];
wire s_uv      = sync2_r[3];
wire s_uvrel   = sync2_r[4];
wire s_ov      = sync2_r[5];
wire s_ovrel   = sync2_r[6];
wire s_inp     = sync2_r[7];
wire s_abn     = sync2_r[8];
wire s_aboveref = sync2_r[9];
wire s_pinrail = sync2_r[10];
wire s_refgnd  = sync2_r[11];

// ****************************************************************
// Sequencer states
// ****************************************************************
localparam [4:0] ST_IDLE    = 5'h01;
localparam [4:0] ST_HOTPLUG = 5'h02;
localparam [4:0] ST_COLD    = 5'h04;
localparam [4:0] ST_BOOST   = 5'h08;
localparam [4:0] ST_WAIT    = 5'h10;

reg  [4:0]              state_r;
reg  [4:0]              state_nxt;
reg  [`HCS_CNT_W-1:0]   win_cnt_r;
reg  [`HCS_CNT_W-1:0]   per_cnt_r;
reg  [`HCS_CNT_W-1:0]   smp_cnt_r;
reg                     holdoff_r;
reg                     sampling_r;
reg                     ov_lock_r;
reg                     attach_d_r;
reg                     sw_r;
reg  [31:0]             ctrl_r;

// Pin at the rail hands the reference to the outside
wire track_en  = ctrl_r[`HCS_CTRL_TRACK] & ~s_pinrail;  // [R13]
// Edge, not level: a level would re-arm the window while attached
wire attach_rise = s_attach & ~attach_d_r;

function cnt_done;
  input [`HCS_CNT_W-1:0] cnt;
  input [`HCS_CNT_W-1:0] lim;
  begin
    cnt_done = (cnt >= lim - 1'b1);
  end
endfunction

always @*
begin
  state_nxt = state_r;
  case (state_r)
    ST_IDLE:
    begin
      if (attach_rise && !s_gnd)
        state_nxt = ST_HOTPLUG;  // [R1]
      else if (attach_rise && s_gnd)
        state_nxt = ST_WAIT;  // [R4]
      else if (s_inp)
        state_nxt = ST_COLD;
    end
    ST_HOTPLUG:
    begin
      if (s_uv)
        state_nxt = s_boostlv ? ST_BOOST : ST_COLD;  // [R2]
      else if (cnt_done(win_cnt_r, HOTPLUG_CYC))
        state_nxt = ST_COLD;  // [R3]
    end
    ST_WAIT:
      if (s_inp)
        state_nxt = s_boostlv ? ST_BOOST : ST_COLD;  // [R4]
    ST_COLD:
      if (s_boostlv)
        state_nxt = ST_BOOST;  // [R7] [R15]
    // Losing the boost level falls back to cold start
    ST_BOOST:
      if (!s_boostlv)
        state_nxt = ST_COLD;
    default:
      state_nxt = ST_IDLE;
  endcase
end

// ****************************************************************
// State, counters and switch
// ****************************************************************
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    state_r    <= ST_IDLE;
    win_cnt_r  <= {`HCS_CNT_W{1'b0}};  // [R18]
    per_cnt_r  <= {`HCS_CNT_W{1'b0}};
    smp_cnt_r  <= {`HCS_CNT_W{1'b0}};
    holdoff_r  <= 1'b0;
    sampling_r <= 1'b0;
    ov_lock_r  <= 1'b0;
    attach_d_r <= 1'b0;
    sw_r       <= 1'b0;
  end
  else
  begin
    state_r    <= state_nxt;
    attach_d_r <= s_attach;
    win_cnt_r  <= (state_r == ST_HOTPLUG) ? win_cnt_r + 1'b1 : {`HCS_CNT_W{1'b0}};
    // Holdoff and sampling share smp_cnt_r; holdoff starts at main boost entry, sampling at each period end after it while track_en is set
    if (state_r != ST_BOOST)
    begin
      holdoff_r  <= 1'b1;
      sampling_r <= 1'b0;
      smp_cnt_r  <= {`HCS_CNT_W{1'b0}};
      per_cnt_r  <= {`HCS_CNT_W{1'b0}};
    end
    else if (holdoff_r)
    begin
      smp_cnt_r <= smp_cnt_r + 1'b1;
      if (cnt_done(smp_cnt_r, HOLDOFF_CYC))  // [R9]
      begin
        holdoff_r <= 1'b0;
        smp_cnt_r <= {`HCS_CNT_W{1'b0}};
      end
    end
    else
    begin
      per_cnt_r <= cnt_done(per_cnt_r, PERIOD_CYC) ? {`HCS_CNT_W{1'b0}} : per_cnt_r + 1'b1;
      if (track_en && cnt_done(per_cnt_r, PERIOD_CYC))
        sampling_r <= 1'b1;  // [R12]
      if (sampling_r)
      begin
        smp_cnt_r <= smp_cnt_r + 1'b1;
        if (cnt_done(smp_cnt_r, SAMPLE_CYC))
        begin
          sampling_r <= 1'b0;
          smp_cnt_r  <= {`HCS_CNT_W{1'b0}};
        end
      end
    end
    // Overvoltage lock cleared only below release level
    if (s_ov)
      ov_lock_r <= 1'b1;  // [R11]
    else if (!s_ovrel)
      ov_lock_r <= 1'b0;  // [R17]
    // Storage switch
    if (state_r == ST_HOTPLUG)
      sw_r <= ~cnt_done(win_cnt_r, HOTPLUG_CYC) | s_uv;  // [R1] [R2] [R3]
    else if (!s_uv)
      sw_r <= 1'b0;  // [R5] [R16]
    else if (state_r == ST_BOOST && s_uvrel)
      sw_r <= 1'b1;  // [R8]
  end
end

// ****************************************************************
// Registered outputs
// ****************************************************************
wire boost_ok  = (state_r == ST_BOOST) & ~s_abn & ~ov_lock_r & ~s_ov;  // [R6] [R11]
wire charge_ok = boost_ok & ~holdoff_r & ~sampling_r;  // [R9] [R12]
// Grounded reference: regulation off, so pulses are not gated by it
wire ref_ok    = s_refgnd | s_aboveref;  // [R10] [R14]

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    storage_switch_on <= 1'b0;
    cold_start_en     <= 1'b0;
    main_boost_en     <= 1'b0;
    charger_en        <= 1'b0;
    transfer_pulse    <= 1'b0;
    sample_en         <= 1'b0;
  end
  else
  begin
    storage_switch_on <= sw_r;  // [R19]
    cold_start_en     <= (state_r == ST_COLD) & s_inp & ~s_abn;  // [R7]
    main_boost_en     <= boost_ok;  // [R7]
    charger_en        <= charge_ok;
    transfer_pulse    <= charge_ok & ref_ok;  // [R10]
    sample_en         <= sampling_r | (boost_ok & holdoff_r & track_en);  // [R13]
  end
end

// ****************************************************************
// Events and Wishbone slave
// ****************************************************************
reg  [`HCS_EV_W-1:0] irq_r;
reg  [`HCS_EV_W-1:0] mask_r;
reg  [4:0]           state_d_r;
reg                  ov_d_r;
reg                  abn_d_r;
reg                  smp_d_r;
reg                  sw_d_r;
wire [`HCS_EV_W-1:0] ev;
assign ev[`HCS_EV_HP_FAIL] = (state_d_r == ST_HOTPLUG) && (state_r == ST_COLD);
assign ev[`HCS_EV_UV]      = sw_d_r & ~sw_r & (state_d_r != ST_HOTPLUG);
assign ev[`HCS_EV_OV]      = ov_lock_r & ~ov_d_r;
assign ev[`HCS_EV_ABN]     = s_abn & ~abn_d_r;
assign ev[`HCS_EV_SAMPLE]  = smp_d_r & ~sampling_r;
assign ev[`HCS_EV_BOOST]   = (state_r == ST_BOOST) && (state_d_r != ST_BOOST);

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    wb_ack_o  <= 1'b0;
    wb_dat_o  <= 32'h0000_0000;
    ctrl_r    <= `HCS_CTRL_RESET;
    irq_r     <= {`HCS_EV_W{1'b0}};
    mask_r    <= {`HCS_EV_W{1'b0}};
    state_d_r <= ST_IDLE;
    ov_d_r    <= 1'b0;
    abn_d_r   <= 1'b0;
    smp_d_r   <= 1'b0;
    sw_d_r    <= 1'b0;
    irq       <= 1'b0;
  end
  else
  begin
    state_d_r <= state_r;
    ov_d_r    <= ov_lock_r;
    abn_d_r   <= s_abn;
    smp_d_r   <= sampling_r;
    sw_d_r    <= sw_r;
    // One ack per taken request; ack high masks a strobe still held
    wb_ack_o  <= wb_req;
    // New events win over a write-one clear in the same cycle
    irq_r <= (irq_r & ~((wb_wr && wb_adr_i == `HCS_ADDR_IRQ) ?
              wb_dat_i[`HCS_EV_W-1:0] : {`HCS_EV_W{1'b0}})) | ev;
    irq   <= |(irq_r & mask_r);
    if (wb_wr && wb_adr_i == `HCS_ADDR_CTRL)
      ctrl_r <= {31'h0000_0000, wb_dat_i[`HCS_CTRL_TRACK]};
    if (wb_wr && wb_adr_i == `HCS_ADDR_MASK)
      mask_r <= wb_dat_i[`HCS_EV_W-1:0];
    if (wb_req)
    begin
      case (wb_adr_i)
        `HCS_ADDR_CTRL: wb_dat_o <= ctrl_r;
        `HCS_ADDR_STAT: wb_dat_o <= {21'h000000, ov_lock_r, sampling_r, holdoff_r,
                                     sw_r, state_r, s_inp, s_uv};
        `HCS_ADDR_IRQ:  wb_dat_o <= {26'h0000000, irq_r};
        `HCS_ADDR_MASK: wb_dat_o <= {26'h0000000, mask_r};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
end

endmodule // hcs_sequencer

// ==== hcs_chk.sv ====
// Port-level checks of the charge sequencer
`timescale 1ns/1ps
module hcs_chk
#(
  parameter HOTPLUG_CYC = 20
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Comparators
  input wire logic rail_above_uv,
  input wire logic rail_above_ov,
  input wire logic input_above_rail,
  input wire logic input_above_reference,
  input wire logic reference_grounded,
  // Controls
  input wire logic storage_switch_on,
  input wire logic cold_start_en,
  input wire logic main_boost_en,
  input wire logic charger_en,
  input wire logic transfer_pulse,
  input wire logic sample_en,
  input wire logic irq
);
  // ******
  // Helpers
  // ******
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  int hp_cnt_r;
  // Counts only while the switch holds up a low rail before boost
  always @(posedge clk or negedge rstn)
    if (!rstn)
      hp_cnt_r <= 0;
    else if (storage_switch_on && !main_boost_en && !rail_above_uv)
      hp_cnt_r <= hp_cnt_r + 1;
    else
      hp_cnt_r <= 0;
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence uv_drop;
    $fell(rail_above_uv) ##1 !rail_above_uv [*4];
  endsequence
  // ******
  // Checks
  // ******
  a_ack_one_pulse: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  a_reset_quiet: assert property ($rose(rstn) |->
    !(storage_switch_on || cold_start_en || main_boost_en || charger_en || irq))
    else $error("output active after reset");
  a_hotplug_window: assert property (hp_cnt_r <= HOTPLUG_CYC + 6)
    else $error("hot-plug switch held too long");
  a_uv_opens: assert property (uv_drop |=> !storage_switch_on)
    else $error("switch closed under low rail");
  a_abnormal_off: assert property (input_above_rail [*5] |-> !charger_en && !main_boost_en)
    else $error("converter active on abnormal input");
  a_holdoff_quiet: assert property ($rose(main_boost_en) |=> !charger_en [*8])
    else $error("charger on inside holdoff");
  a_pulse_ref: assert property
    ((!input_above_reference && !reference_grounded) [*5] |-> !transfer_pulse)
    else $error("pulse below reference");
  a_ov_stops: assert property (rail_above_ov [*5] |-> !main_boost_en)
    else $error("boost on at overvoltage");
  a_sample_halts: assert property (sample_en |-> !charger_en)
    else $error("charger on while sampling");
endmodule // hcs_chk

bind hcs_sequencer hcs_chk #(.HOTPLUG_CYC(HOTPLUG_CYC)) i_hcs_chk (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rail_above_uv(rail_above_uv), .rail_above_ov(rail_above_ov),
  .input_above_rail(input_above_rail), .input_above_reference(input_above_reference),
  .reference_grounded(reference_grounded), .storage_switch_on(storage_switch_on),
  .cold_start_en(cold_start_en), .main_boost_en(main_boost_en), .charger_en(charger_en),
  .transfer_pulse(transfer_pulse), .sample_en(sample_en), .irq(irq)
);

// ==== hcs_plant.sv ====
// Analog far side: rail level with its threshold comparators
`timescale 1ns/1ps
module hcs_plant
(
  // Clock
  input  wire logic clk,
  // Power stage controls
  input  wire logic cold_start_en,
  input  wire logic main_boost_en,
  input  wire logic storage_switch_on,
  // Scenario knobs
  input  wire logic storage_charged,
  input  wire logic load_dump,
  // Comparators
  output logic      rail_above_ground,
  output logic      rail_above_boost_level,
  output logic      rail_above_uv,
  output logic      rail_above_uv_release,
  output logic      rail_above_ov,
  output logic      storage_above_ov_release
);
  logic [7:0] rail_r = 8'h00;
  // ******
  // Rail
  // ******
  // One step a cycle keeps each upward threshold crossing slow and visible; load dump drops the rail straight to zero
  always @(posedge clk)
  begin
    if (load_dump)
      rail_r <= 8'h00;
    else if (rail_r != 8'hff && (cold_start_en || main_boost_en
             || storage_switch_on && storage_charged))
      rail_r <= rail_r + 8'h01;
  end
  assign rail_above_ground      = rail_r != 8'h00;
  assign rail_above_boost_level = rail_r >= 8'h28;
  assign rail_above_uv          = rail_r >= 8'h3c;
  assign rail_above_uv_release  = rail_r >= 8'h46;
  assign rail_above_ov          = rail_r >= 8'hc8;
  // Storage follows the rail; its release level sits below the trip
  assign storage_above_ov_release = rail_r >= 8'hb4;
endmodule // hcs_plant

// ==== hcs_sequencer_tb.sv ====
// Self-checking bench of the charge sequencer
`timescale 1ns/1ps
`include "hcs_regs.vh"
module hcs_sequencer_tb;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] want;
  } hcs_row_t;
  logic        clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0]  wb_sel_i;
  logic        storage_attached, rail_above_ground, rail_above_boost_level, rail_above_uv;
  logic        rail_above_uv_release, rail_above_ov, storage_above_ov_release, input_present;
  logic        input_above_rail, input_above_reference, sample_pin_at_rail, reference_grounded;
  logic        storage_switch_on, cold_start_en, main_boost_en, charger_en, transfer_pulse;
  logic        sample_en, irq, storage_charged, load_dump;
  int          mismatches, samples_checked, cyc_cnt, n, hits;
  wire  [5:0]  outs = {transfer_pulse, sample_en, charger_en, main_boost_en, cold_start_en,
                       storage_switch_on};
  hcs_row_t    rows [6] = '{'{1'b0, `HCS_ADDR_CTRL, 32'h0, 32'h1},
                            '{1'b0, `HCS_ADDR_IRQ, 32'h0, 32'h0},
                            '{1'b1, `HCS_ADDR_CTRL, 32'h0, 32'h0},
                            '{1'b0, `HCS_ADDR_CTRL, 32'h0, 32'h0},
                            '{1'b1, `HCS_ADDR_CTRL, 32'h1, 32'h0},
                            '{1'b0, 8'h10, 32'h0, 32'h0}};

  hcs_sequencer #(.HOTPLUG_CYC(20), .HOLDOFF_CYC(10), .PERIOD_CYC(200), .SAMPLE_CYC(15))
    i_hcs_sequencer (.*);
  hcs_plant i_hcs_plant (.*);

  // ******
  // Tasks
  // ******
  task ck(input string s, input logic [31:0] e, input logic [31:0] g);
    begin
      samples_checked++;
      if (g !== e)
      begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task te(input string s);
    $display("test %s done", s);
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    begin
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do
      begin
        @(posedge clk);
      end
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  // Waits for one control output to reach a level; n tells how long
  task wt(input int k, input logic v, output int c);
    begin
      c = 0;
      while (outs[k] !== v)
      begin
        @(posedge clk);
        c++;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // ******
  // Clock, timeout
  // ******
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // ******
  // Scenarios
  // ******
  initial
  begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, storage_attached, input_present} = '0;
    {input_above_rail, input_above_reference, sample_pin_at_rail, reference_grounded} = '0;
    {storage_charged, load_dump, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    ck("outputs", 32'h0, {outs, irq});
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].adr, rows[i].wd, rd);
      if (!rows[i].we)
        ck("register", rows[i].want, rd);
    end
    te("registers");
    // Empty storage: window must run out, then cold start takes over
    @(posedge clk);
    storage_attached <= 1'b1;
    wt(0, 1'b1, n);
    input_present <= 1'b1;
    input_above_reference <= 1'b1;
    wt(0, 1'b0, n);
    ck("window", 32'h1, n > 15 && n < 27);
    wt(1, 1'b1, n);
    ck("cold start", 32'h1, n < 7);
    te("hotplug");
    wt(2, 1'b1, n);
    ck("boost level", 32'h1, rail_above_boost_level);
    ck("first sample", 32'h1, sample_en);
    ck("holdoff charger", 32'h0, charger_en);
    wt(0, 1'b1, n);
    ck("uv release", 32'h1, rail_above_uv_release);
    ck("pulse", 32'h1, transfer_pulse);
    input_above_reference <= 1'b0;
    repeat (5) @(posedge clk);
    ck("pulse gated", 32'h0, transfer_pulse);
    reference_grounded <= 1'b1;
    repeat (5) @(posedge clk);
    ck("grounded ref", 32'h1, transfer_pulse);
    input_above_reference <= 1'b1;
    reference_grounded <= 1'b0;
    wt(2, 1'b0, n);
    ck("ov", 32'h1, rail_above_ov);
    wb(1'b0, `HCS_ADDR_IRQ, 32'h0, rd);
    ck("events", 32'h25, rd & 32'h25);
    te("boost");
    wb(1'b1, `HCS_ADDR_MASK, 32'h1, rd);
    repeat (3) @(posedge clk);
    ck("irq set", 32'h1, irq);
    wb(1'b1, `HCS_ADDR_IRQ, 32'h1, rd);
    repeat (3) @(posedge clk);
    ck("irq clear", 32'h0, irq);
    te("interrupt");
    // Periodic sample window, then the pin at the rail must stop the next one
    wt(4, 1'b1, n);
    wt(4, 1'b0, n);
    ck("sample length", 32'd15, n);
    sample_pin_at_rail <= 1'b1;
    hits = 0;
    repeat (220)
    begin
      @(posedge clk);
      hits += sample_en;
    end
    ck("pin at rail", 32'h0, hits);
    sample_pin_at_rail <= 1'b0;
    te("sampling");
    load_dump <= 1'b1;
    @(posedge clk);
    load_dump <= 1'b0;
    wt(0, 1'b0, n);
    ck("uv open", 32'h1, n < 8);
    input_above_rail <= 1'b1;
    repeat (8) @(posedge clk);
    ck("abnormal", 32'h0, outs[3:1]);
    te("faults");
    // Mid-run reset, then a charged element plugged onto a live rail
    {input_present, storage_attached, input_above_rail} <= 3'b000;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    ck("reset outputs", 32'h0, {outs, irq});
    storage_charged <= 1'b1;
    storage_attached <= 1'b1;
    repeat (8) @(posedge clk);
    ck("charged plug", 32'h0, storage_switch_on);
    input_present <= 1'b1;
    wt(1, 1'b1, n);
    ck("resume", 32'h1, n < 8);
    te("reset");
    print_verdict();
  end
endmodule // hcs_sequencer_tb
